// [rx_shifter.v]
// Receive shift register: LSB first, eight or nine bits per word.
`timescale 1ns/1ns

module rx_shifter #(
   parameter WORD_BITS = 9
) (
   input wire clock_in, // System oscillator.
   input wire rst_in, // Synchronous reset, active high.
   input wire clear_in, // Drops a partial word.
   input wire sample_in, // Take one bit now.
   input wire bit_in, // Data line level.
   input wire nine_in, // Nine bits per word when high.
   output wire [WORD_BITS-1:0] word_out, // Assembled word.
   output reg done_out, // One-cycle pulse after the last bit.
   output wire busy_out // A word is partly received.
);

   reg [WORD_BITS-1:0] shift;
   reg [3:0] count;
   wire [3:0] last;
   genvar i;

   assign last = nine_in ? 4'h8 : 4'h7;
   assign busy_out = (count != 4'h0);
   assign word_out = nine_in ? shift : {1'b0, shift[WORD_BITS-2:0]};

   // ============================================================
   // One shift stage per bit; the top stage in use takes the line.
   generate
      for (i = 0; i < WORD_BITS; i = i + 1)
      begin : g_stage
         always @(posedge clock_in)
         begin
            if (rst_in)
               shift[i] <= 1'b0;
            else if (sample_in)
            begin
               if (i == WORD_BITS - 1)
                  shift[i] <= bit_in;
               else if (i == WORD_BITS - 2 && !nine_in)
                  shift[i] <= bit_in;
               else
                  shift[i] <= shift[(i + 1) % WORD_BITS];
            end
         end
      end
   endgenerate

   // Bit counter and word-complete pulse.
   always @(posedge clock_in)
   begin
      if (rst_in || clear_in)
      begin
         count <= 4'h0;
         done_out <= 1'b0;
      end
      else if (sample_in)
      begin
         done_out <= (count == last);
         count <= (count == last) ? 4'h0 : count + 4'h1;
      end
      else
         done_out <= 1'b0;
   end

endmodule // rx_shifter

// [shift_clock_gen.v]
// Shift clock generator: oscillator/(4*(n+1)) with a falling-edge sample pulse.
`timescale 1ns/1ns
`include "sync_rx_map.vh"

module shift_clock_gen #(
   parameter DIV_WIDTH = 8
) (
   input wire clock_in, // System oscillator.
   input wire rst_in, // Synchronous reset, active high.
   input wire run_in, // Clock runs while high, idles low otherwise.
   input wire [DIV_WIDTH-1:0] divider_in, // Divider value n.
   output reg level_out, // Shift clock level.
   output reg fall_out // One-cycle pulse as the clock falls.
);

   reg [DIV_WIDTH+1:0] count;
   wire [DIV_WIDTH+1:0] half_period;

   // Half a period is 2*(n+1) oscillator cycles.
   assign half_period = {2'b00, divider_in} + {{DIV_WIDTH{1'b0}}, 2'b01}
                        + {2'b00, divider_in} + {{DIV_WIDTH{1'b0}}, 2'b01};

   // ============================================================
   // Divider.
   // divider rate
   always @(posedge clock_in)
   begin
      if (rst_in || !run_in)
      begin
         count <= {(DIV_WIDTH+2){1'b0}};
         level_out <= 1'b0;
         fall_out <= 1'b0;
      end
      else if (count == half_period - {{(DIV_WIDTH+1){1'b0}}, 1'b1})
      begin
         count <= {(DIV_WIDTH+2){1'b0}};
         level_out <= ~level_out;
         fall_out <= level_out;
      end
      else
      begin
         count <= count + {{(DIV_WIDTH+1){1'b0}}, 1'b1};
         fall_out <= 1'b0;
      end
   end

endmodule // shift_clock_gen

// [sync_rx_map.vh]
// Register offsets, field positions, reset values and timing factors of the receiver.
`ifndef SYNC_RX_MAP_VH
`define SYNC_RX_MAP_VH

// ============================================================
// Register offsets on the plain register port.
`define OFS_RX_CTRL_STATUS 3'h0
`define OFS_RX_DATA 3'h1
`define OFS_TX_CTRL_STATUS 3'h2
`define OFS_BAUD_DIVIDER 3'h3
`define OFS_PERIPH_FLAGS 3'h4
`define OFS_PERIPH_ENABLES 3'h5
`define OFS_PERIPH_PRIOS 3'h6
`define OFS_CORE_IRQ_CTRL 3'h7

// ============================================================
// Fields of receive_control_status.
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_NINE_BIT_RECEIVE_SELECT 6
`define BIT_SINGLE_RECEIVE_ENABLE 5
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_ADDRESS_DETECT_ENABLE 3
`define BIT_FRAMING_ERROR_FLAG 2
`define BIT_OVERRUN_ERROR_FLAG 1
`define BIT_RECEIVED_NINTH_BIT 0

// ============================================================
// Fields of transmit_control_status and of the interrupt registers.
`define BIT_CLOCK_SOURCE_MASTER 7
`define BIT_SYNC_MODE_SELECT 4
`define BIT_SHIFT_REGISTER_EMPTY 1
`define BIT_RECEIVE_IRQ 5

// ============================================================
// Reset values.
`define RST_BYTE 8'h00
`define RST_TX_CTRL_STATUS 8'h02

// ============================================================
// Shift clock period is this many oscillator cycles per divider step.
`define SYNC_CLK_FACTOR 10'h004
`endif

// [sync_serial_master_receiver.v]
// Synchronous master receive path with register port and interrupt.
`timescale 1ns/1ns
`include "sync_rx_map.vh"

module sync_serial_master_receiver #(
   parameter DIV_WIDTH = 8,
   parameter WORD_BITS = 9
) (
   input wire clock_in, // System oscillator, 100 MHz.
   input wire rst_in, // Synchronous reset, active high.
   input wire [2:0] addr_in, // Register address.
   input wire [7:0] wdata_in, // Write data.
   input wire write_in, // Write strobe, one cycle.
   input wire read_in, // Read strobe, one cycle.
   output reg [7:0] rdata_out, // Read data, valid the cycle after a read.
   input wire serial_data_pin_in, // Data line from the slave.
   output wire shift_clock_out, // Shift clock level.
   output reg shift_clock_oe_out, // Shift clock drive enable.
   output reg irq_out // Interrupt request, level, active high.
);

   // ============================================================
   // Register map, one byte each on the plain port.
   // receive_control_status: port enable, nine-bit select, single and continuous
   // enables, address detect (stored only), then framing error, overrun error and
   // the ninth bit of the visible word, these three read only.
   // receive_data: low eight bits of the visible word, read only.
   // transmit_control_status: clock source and sync select; the shift register
   // empty bit always reads one and bit 3 reads zero, the rest are stored.
   // baud_divider: the divider value n of the shift clock.
   // peripheral_flags_one: the receive flag, cleared by writing a one to it while no word waits in the second slot.
   // peripheral_enables_one: the receive interrupt enable in the same position.
   // The priority and core interrupt registers are stored and read back only,
   // since nothing in this block consumes them.

   // ============================================================
   // Software registers.
   reg serial_port_enable;
   reg nine_bit_receive_select;
   reg single_receive_enable;
   reg continuous_receive_enable;
   reg address_detect_enable;
   reg framing_error_flag;
   reg overrun_error_flag;
   reg clock_source_master;
   reg sync_mode_select;
   reg [7:0] tx_spare;
   reg [DIV_WIDTH-1:0] baud_divider;
   reg [7:0] peripheral_enables_one;
   reg [7:0] peripheral_priorities_one;
   reg [7:0] core_interrupt_control;

   // ============================================================
   // Two-word receive buffer: the visible word and one waiting behind it.
   reg [WORD_BITS-1:0] receive_data;
   reg [WORD_BITS-1:0] waiting_word;
   reg waiting_full;
   reg receive_irq_flag;

   reg active;
   reg [7:0] next_rdata;

   wire word_done;
   wire [WORD_BITS-1:0] word;
   wire sample;
   wire shifter_busy;
   wire master_sync;
   wire want_receive;
   wire write_ctrl;
   wire read_data;
   wire clear_continuous_receive_enable;
   wire irq_flag_clear;
   wire [7:0] rx_ctrl_status;
   wire [7:0] tx_ctrl_status;
   wire [7:0] peripheral_flags_one;

   assign write_ctrl = write_in && (addr_in == `OFS_RX_CTRL_STATUS);
   assign read_data = read_in && (addr_in == `OFS_RX_DATA);
   assign clear_continuous_receive_enable = write_ctrl && !wdata_in[`BIT_CONTINUOUS_RECEIVE_ENABLE];
   assign irq_flag_clear = write_in && (addr_in == `OFS_PERIPH_FLAGS)
                           && wdata_in[`BIT_RECEIVE_IRQ];

   // Master synchronous operation needs all three mode bits.
   // Without them the enables are only stored, so software may set up the
   // registers in any order and nothing moves before the last step.
   assign master_sync = serial_port_enable && sync_mode_select && clock_source_master;
   assign want_receive = master_sync && (single_receive_enable || continuous_receive_enable);

   // ============================================================
   // Shift clock and shift register.
   // The generator is held in reset while reception is idle, so the first word
   // of each reception starts on a fresh low phase of the shift clock.
   shift_clock_gen #(
      .DIV_WIDTH(DIV_WIDTH)
   ) u_clock (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .run_in(active),
      .divider_in(baud_divider),
      .level_out(shift_clock_out),
      .fall_out(sample)
   );

   rx_shifter #(
      .WORD_BITS(WORD_BITS)
   ) u_shift (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .clear_in(!active),
      .sample_in(sample),
      .bit_in(serial_data_pin_in),
      .nine_in(nine_bit_receive_select),
      .word_out(word),
      .done_out(word_done),
      .busy_out(shifter_busy)
   );

   // ============================================================
   // Reception activity. An overrun stops reception until it is cleared, since
   // further words would have nowhere to go.
   // Timing: active follows the enabling write by one cycle, the pin drive
   // follows active by one more, and the first bit is taken one cycle after the
   // first falling edge of the shift clock, about 4*(n+1) cycles after active.
   always @(posedge clock_in)
   begin
      if (rst_in)
         active <= 1'b0;
      else
         active <= want_receive && !overrun_error_flag
                   && !(word_done && !continuous_receive_enable);
   end

   always @(posedge clock_in)
   begin
      if (rst_in)
         shift_clock_oe_out <= 1'b0;
      else
         shift_clock_oe_out <= active;
   end

   // ============================================================
   // Receive control/status register. Software writes the control bits; the
   // error bits are set by hardware and cleared by a write with the continuous enable at zero; the ninth bit follows the received word.
   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         serial_port_enable <= 1'b0;
         nine_bit_receive_select <= 1'b0;
         single_receive_enable <= 1'b0;
         continuous_receive_enable <= 1'b0;
         address_detect_enable <= 1'b0;
      end
      else if (write_ctrl)
      begin
         serial_port_enable <= wdata_in[`BIT_SERIAL_PORT_ENABLE];
         nine_bit_receive_select <= wdata_in[`BIT_NINE_BIT_RECEIVE_SELECT];
         single_receive_enable <= wdata_in[`BIT_SINGLE_RECEIVE_ENABLE];
         continuous_receive_enable <= wdata_in[`BIT_CONTINUOUS_RECEIVE_ENABLE];
         address_detect_enable <= wdata_in[`BIT_ADDRESS_DETECT_ENABLE];
      end
      else if (word_done && !continuous_receive_enable)
         single_receive_enable <= 1'b0;
   end

   // Framing error: reception was switched off with a word half shifted in.
   // The partial word is thrown away; only the flag tells software of it.
   always @(posedge clock_in)
   begin
      if (rst_in)
         framing_error_flag <= 1'b0;
      else if (shifter_busy && active && !want_receive)
         framing_error_flag <= 1'b1;
      else if (clear_continuous_receive_enable)
         framing_error_flag <= 1'b0;
   end

   // Overrun: a word completes while both buffer slots are full. The new
   // word is lost; the set beats a simultaneous clear.
   always @(posedge clock_in)
   begin
      if (rst_in)
         overrun_error_flag <= 1'b0;
      else if (word_done && receive_irq_flag && waiting_full && !read_data)
         overrun_error_flag <= 1'b1;
      else if (clear_continuous_receive_enable)
         overrun_error_flag <= 1'b0;
   end

   // ============================================================
   // Receive buffer and receive flag.
   // The visible word stays put while its flag is set, so it never changes
   // under a pending read. A word that arrives meanwhile waits in the second
   // slot, and a read in the cycle of a completed word moves both slots along
   // rather than dropping either one.
   // back to back words
   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         receive_data <= {WORD_BITS{1'b0}};
         waiting_word <= {WORD_BITS{1'b0}};
         waiting_full <= 1'b0;
         receive_irq_flag <= 1'b0;
      end
      else
      begin
         if (word_done && (!receive_irq_flag || (read_data && !waiting_full)))
         begin
            receive_data <= word;
            receive_irq_flag <= 1'b1;
         end
         else if (word_done && read_data && waiting_full)
         begin
            receive_data <= waiting_word;
            waiting_word <= word;
         end
         else if (word_done && !waiting_full)
         begin
            waiting_word <= word;
            waiting_full <= 1'b1;
         end
         else if (read_data && waiting_full)
         begin
            receive_data <= waiting_word;
            waiting_full <= 1'b0;
         end
         else if (read_data || (irq_flag_clear && !waiting_full))
            receive_irq_flag <= 1'b0;
      end
   end

   // ============================================================
   // Other writable registers.
   // The divider may be written at any time; a change mid-word bends the bit
   // in progress, so software should change it only while reception is idle.
   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         clock_source_master <= 1'b0;
         sync_mode_select <= 1'b0;
         tx_spare <= `RST_TX_CTRL_STATUS;
         baud_divider <= {DIV_WIDTH{1'b0}};
         peripheral_enables_one <= `RST_BYTE;
         peripheral_priorities_one <= `RST_BYTE;
         core_interrupt_control <= `RST_BYTE;
      end
      else if (write_in)
      begin
         case (addr_in)
            `OFS_TX_CTRL_STATUS:
            begin
               clock_source_master <= wdata_in[`BIT_CLOCK_SOURCE_MASTER];
               sync_mode_select <= wdata_in[`BIT_SYNC_MODE_SELECT];
               tx_spare <= wdata_in;
            end
            `OFS_BAUD_DIVIDER: baud_divider <= wdata_in[DIV_WIDTH-1:0];
            `OFS_PERIPH_ENABLES: peripheral_enables_one <= wdata_in;
            `OFS_PERIPH_PRIOS: peripheral_priorities_one <= wdata_in;
            `OFS_CORE_IRQ_CTRL: core_interrupt_control <= wdata_in;
            default: tx_spare <= tx_spare;
         endcase
      end
   end

   // ============================================================
   // Read views.
   // ninth bit readback
   assign rx_ctrl_status = {serial_port_enable, nine_bit_receive_select,
                            single_receive_enable, continuous_receive_enable,
                            address_detect_enable, framing_error_flag,
                            overrun_error_flag, receive_data[WORD_BITS-1]};
   // The receive path never transmits, so the shift register always reads empty.
   assign tx_ctrl_status = {clock_source_master, tx_spare[6:5], sync_mode_select,
                            1'b0, tx_spare[2], 1'b1, tx_spare[0]};
   assign peripheral_flags_one = {2'b00, receive_irq_flag, 5'b00000};

   // Read mux; unmapped bits read as zero.
   // Decoding on the address alone keeps the mux small; the strobe only gates
   // the output register below.
   always @*
   begin
      next_rdata = `RST_BYTE;
      case (addr_in)
         `OFS_RX_CTRL_STATUS: next_rdata = rx_ctrl_status;
         `OFS_RX_DATA: next_rdata = receive_data[7:0];
         `OFS_TX_CTRL_STATUS: next_rdata = tx_ctrl_status;
         `OFS_BAUD_DIVIDER: next_rdata = baud_divider;
         `OFS_PERIPH_FLAGS: next_rdata = peripheral_flags_one;
         `OFS_PERIPH_ENABLES: next_rdata = peripheral_enables_one;
         `OFS_PERIPH_PRIOS: next_rdata = peripheral_priorities_one;
         `OFS_CORE_IRQ_CTRL: next_rdata = core_interrupt_control;
         default: next_rdata = `RST_BYTE;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   // Zero between answers lets the port share a bus with others by a plain OR.
   always @(posedge clock_in)
   begin
      if (rst_in || !read_in)
         rdata_out <= `RST_BYTE;
      else
         rdata_out <= next_rdata;
   end

   // ============================================================
   // Interrupt: flag gated by its enable.
   // The request is registered, so it trails the flag and the enable by one
   // cycle; after a clearing read it may stand for one more cycle.
   // enable gates request
   always @(posedge clock_in)
   begin
      if (rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(peripheral_flags_one & peripheral_enables_one);
   end

endmodule // sync_serial_master_receiver

// [sync_serial_master_receiver_properties.sv]
// Port-level checker for the synchronous master receiver.
`timescale 1ns/1ns
`include "sync_rx_map.vh"

module sync_rx_checker #(
   parameter DIV_WIDTH = 8,
   parameter WORD_BITS = 9
) (
   input wire clock_in, // System oscillator.
   input wire rst_in, // Synchronous reset.
   input wire [2:0] addr_in, // Register address.
   input wire [7:0] wdata_in, // Write data.
   input wire write_in, // Write strobe.
   input wire read_in, // Read strobe.
   input wire [7:0] rdata_out, // Read data.
   input wire serial_data_pin_in, // Data line.
   input wire shift_clock_out, // Shift clock level.
   input wire shift_clock_oe_out, // Shift clock enable.
   input wire irq_out // Interrupt request.
);
   reg [7:0] ctrl_copy;
   reg [7:0] div_copy;
   reg [7:0] en_copy;
   reg [10:0] level_len;
   reg last_level;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // ============================================================
   // Shadows of software writes and a counter of cycles per clock level.
   always @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ctrl_copy <= 8'h00;
         div_copy <= 8'h00;
         en_copy <= 8'h00;
         level_len <= 11'h000;
         last_level <= 1'b0;
      end
      else
      begin
         if (write_in && addr_in == `OFS_RX_CTRL_STATUS) ctrl_copy <= wdata_in;
         if (write_in && addr_in == `OFS_BAUD_DIVIDER) div_copy <= wdata_in;
         if (write_in && addr_in == `OFS_PERIPH_ENABLES) en_copy <= wdata_in;
         level_len <= (shift_clock_out != last_level) ? 11'h001 : level_len + 11'h001;
         last_level <= shift_clock_out;
      end
   end

   // ============================================================
   // Outputs come out of reset quiet.
   AST_RESET_QUIET: assert property ($fell(rst_in) |-> rdata_out == 8'h00 && !irq_out
      && !shift_clock_oe_out && !shift_clock_out) else $error("outputs not quiet after reset");
   AST_RDATA_IDLE: assert property (!$past(read_in) |-> rdata_out == 8'h00)
      else $error("read data outside the answer cycle");
   AST_TX_FIXED_BITS: assert property ($past(read_in) && $past(addr_in) == `OFS_TX_CTRL_STATUS
      |-> rdata_out[1] && !rdata_out[3]) else $error("transmit status fixed bits wrong");
   AST_START_NEEDS_ENABLE: assert property ($rose(shift_clock_oe_out) |-> ctrl_copy[7]
      && (ctrl_copy[5] || ctrl_copy[4])) else $error("clock drive began without an enable");
   AST_CLOCK_ONLY_DRIVEN: assert property (!shift_clock_oe_out |-> !shift_clock_out)
      else $error("shift clock high while not driven");
   AST_CLOCK_FOLLOWS_DRIVE: assert property ($rose(shift_clock_oe_out) |->
      ##[1:511] $rose(shift_clock_out)) else $error("no shift clock after drive began");
   AST_HIGH_PHASE: assert property ($fell(shift_clock_out) && shift_clock_oe_out |->
      level_len == {2'b00, div_copy, 1'b0} + 11'h002) else $error("shift clock high phase wrong");
   AST_IRQ_MASKED: assert property (irq_out |-> $past(en_copy[`BIT_RECEIVE_IRQ]))
      else $error("interrupt raised while disabled");
endmodule // sync_rx_checker

bind sync_serial_master_receiver sync_rx_checker #(.DIV_WIDTH(DIV_WIDTH),
   .WORD_BITS(WORD_BITS)) checker_i (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
   .serial_data_pin_in(serial_data_pin_in), .shift_clock_out(shift_clock_out),
   .shift_clock_oe_out(shift_clock_oe_out), .irq_out(irq_out));

// [sync_serial_master_receiver_tb_top.sv]
// Self-checking testbench of the synchronous master receiver.
`timescale 1ns/1ns
`include "sync_rx_map.vh"

module sync_serial_master_receiver_tb_top;
   reg clock_in = 1'b0;
   reg rst_in = 1'b1;
   reg [2:0] addr_in = 3'h0;
   reg [7:0] wdata_in = 8'h00;
   reg write_in = 1'b0;
   reg read_in = 1'b0;
   reg [8:0] slave_word = 9'h000;
   reg slave_nine = 1'b0;
   reg [7:0] v;
   wire [7:0] rdata_out;
   wire serial_data_pin_in;
   wire shift_clock_out;
   wire shift_clock_oe_out;
   wire irq_out;
   integer miscompares = 0;
   integer check_count = 0;
   integer i;

   // ============================================================
   // Clock, design and slave.
   always #5 clock_in = ~clock_in;
   sync_serial_master_receiver dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
      .serial_data_pin_in(serial_data_pin_in), .shift_clock_out(shift_clock_out),
      .shift_clock_oe_out(shift_clock_oe_out), .irq_out(irq_out));
   sync_slave_model slave (.clock_in(clock_in), .rst_in(rst_in), .sclk_in(shift_clock_out),
      .oe_in(shift_clock_oe_out), .word_in(slave_word), .nine_in(slave_nine),
      .data_out(serial_data_pin_in));

   // ============================================================
   // Bus cycles, comparison and verdict.
   task wr(input [2:0] a, input [7:0] d);
   begin
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
   end
   endtask

   task rd(input [2:0] a, output [7:0] d);
   begin
      @(posedge clock_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 d = rdata_out;
   end
   endtask

   task chk(input [8*12:1] name, input [7:0] seen, input [7:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
   end
   endtask

   task stop_test;
   begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   end
   endtask

   // A bounded wait for a register bit; running out ends the run.
   task poll(input [2:0] a, input integer b, input integer bound);
   begin
      v = 8'h00;
      for (i = 0; i < bound && v[b] !== 1'b1; i = i + 1) rd(a, v);
      if (v[b] !== 1'b1)
      begin
         chk("poll_timeout", 8'h00, 8'h01);
         stop_test;
      end
   end
   endtask

   // ============================================================
   // Scenarios.
   task t_reset;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         rd(i[2:0], v);
         chk("reset_value", v, (i == 2) ? `RST_TX_CTRL_STATUS : `RST_BYTE);
      end
   end
   endtask

   task t_setup(input [7:0] div);
   begin
      wr(`OFS_RX_CTRL_STATUS, 8'h80);
      wr(`OFS_BAUD_DIVIDER, div);
      wr(`OFS_TX_CTRL_STATUS, 8'h90);
      wr(`OFS_PERIPH_ENABLES, 8'h20);
      rd(`OFS_BAUD_DIVIDER, v);
      chk("divider", v, div);
      chk("idle_drive", {7'h00, shift_clock_oe_out}, 8'h00);
   end
   endtask

   task t_single(input [7:0] div, input [7:0] word);
   begin
      slave_nine = 1'b0;
      slave_word = {1'b0, word};
      t_setup(div);
      wr(`OFS_RX_CTRL_STATUS, 8'ha0);
      poll(`OFS_PERIPH_FLAGS, 5, 20 * (div + 1) + 40);
      rd(`OFS_RX_CTRL_STATUS, v);
      chk("irq_raised", {7'h00, irq_out}, 8'h01);
      chk("single_done", v, 8'h80);
      rd(`OFS_RX_DATA, v);
      chk("rx_data", v, word);
      rd(`OFS_PERIPH_FLAGS, v);
      chk("flag_cleared", v & 8'h20, 8'h00);
      chk("irq_dropped", {7'h00, irq_out}, 8'h00);
      chk("drive_off", {7'h00, shift_clock_oe_out}, 8'h00);
   end
   endtask

   task t_cont;
   begin
      slave_nine = 1'b1;
      slave_word = 9'h13c;
      t_setup(8'h00);
      wr(`OFS_RX_CTRL_STATUS, 8'hf0);
      repeat (2)
      begin
         poll(`OFS_PERIPH_FLAGS, 5, 60);
         rd(`OFS_RX_CTRL_STATUS, v);
         chk("ninth_bit", v & 8'h11, 8'h11);
         rd(`OFS_RX_DATA, v);
         chk("rx_data9", v, 8'h3c);
         chk("still_on", {7'h00, shift_clock_oe_out}, 8'h01);
      end
      poll(`OFS_RX_CTRL_STATUS, `BIT_OVERRUN_ERROR_FLAG, 200);
      repeat (2) @(posedge clock_in);
      #1 chk("overrun_stop", {7'h00, shift_clock_oe_out}, 8'h00);
      wr(`OFS_RX_CTRL_STATUS, 8'hc0);
      rd(`OFS_RX_CTRL_STATUS, v);
      chk("errors_clear", v & 8'h06, 8'h00);
      rd(`OFS_RX_DATA, v);
      rd(`OFS_RX_DATA, v);
      chk("rx_data_last", v, 8'h3c);
   end
   endtask

   task t_mask;
   begin
      slave_nine = 1'b0;
      slave_word = 9'h05a;
      wr(`OFS_RX_CTRL_STATUS, 8'h80);
      wr(`OFS_PERIPH_ENABLES, 8'h00);
      wr(`OFS_RX_CTRL_STATUS, 8'ha0);
      poll(`OFS_PERIPH_FLAGS, 5, 60);
      chk("irq_masked", {7'h00, irq_out}, 8'h00);
      wr(`OFS_PERIPH_ENABLES, 8'h20);
      @(posedge clock_in);
      #1 chk("irq_unmasked", {7'h00, irq_out}, 8'h01);
      rd(`OFS_RX_DATA, v);
      chk("rx_data_m", v, 8'h5a);
      repeat (2) @(posedge clock_in);
      #1 chk("irq_off", {7'h00, irq_out}, 8'h00);
   end
   endtask

   task t_frame;
   begin
      slave_nine = 1'b0;
      slave_word = 9'h0c6;
      t_setup(8'h00);
      wr(`OFS_RX_CTRL_STATUS, 8'h90);
      repeat (12) @(posedge clock_in);
      wr(`OFS_RX_CTRL_STATUS, 8'h80);
      rd(`OFS_RX_CTRL_STATUS, v);
      chk("frame_error", v, 8'h84);
      chk("frame_stop", {7'h00, shift_clock_oe_out}, 8'h00);
      wr(`OFS_RX_CTRL_STATUS, 8'h80);
      rd(`OFS_RX_CTRL_STATUS, v);
      chk("frame_clear", v, 8'h80);
   end
   endtask

   // ============================================================
   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      t_reset;
      t_single(8'h01, 8'ha5);
      t_single(8'hff, 8'hc3);
      t_cont;
      t_mask;
      t_frame;
      stop_test;
   end
endmodule // sync_serial_master_receiver_tb_top

// [sync_slave_model.sv]
// Behavioural serial slave that feeds words to the master receiver.
`timescale 1ns/1ns

module sync_slave_model (
   input wire clock_in, // System oscillator.
   input wire rst_in, // Synchronous reset.
   input wire sclk_in, // Shift clock from the master.
   input wire oe_in, // Master drives the clock.
   input wire [8:0] word_in, // Word sent repeatedly.
   input wire nine_in, // Nine bits per word.
   output wire data_out // Data line to the master.
);
   reg [3:0] idx;
   reg last_clk;
   reg junk;

   // ============================================================
   // nine bit words
   // A bit changes just after each rise, so it is steady across the sampling fall.
   always @(posedge clock_in)
   begin
      last_clk <= sclk_in;
      junk <= rst_in ? 1'b0 : ~junk;
      if (rst_in || !oe_in) idx <= 4'hf;
      else if (sclk_in && !last_clk) idx <= (idx == (nine_in ? 4'h8 : 4'h7)) ? 4'h0 : idx + 4'h1;
   end

   // Outside a reception the line toggles, so a stale bit can never be mistaken for data.
   assign data_out = oe_in ? ((idx > 4'h8) ? word_in[0] : word_in[idx]) : junk;
endmodule // sync_slave_model
